/* File: rtl/trgro_pkg.sv */
package trgro_pkg;
  // ==========================================================
  // Select codes
  localparam logic [2:0] TRGRO_SEL_OFF = 3'h0;
  localparam logic [2:0] TRGRO_SEL_STAR = 3'h7;
  localparam logic [2:0] TRGRO_SEL_RST = 3'h0;
  // ==========================================================
  // Timing
  localparam int TRGRO_CLK_MHZ = 10;
  localparam int TRGRO_DRDY_US = 100;
  localparam int TRGRO_DRDY_CYC = TRGRO_DRDY_US * TRGRO_CLK_MHZ;
  localparam logic [9:0] TRGRO_DRDY_CNT = 10'(TRGRO_DRDY_CYC);
  // ==========================================================
  // Storage
  localparam int TRGRO_FIFO_DEPTH = 5;
  localparam int TRGRO_BUF_DEPTH = 64;
  localparam int TRGRO_DATA_W = 32;
  localparam logic [2:0] TRGRO_FIFO_FULL = 3'h5;
  localparam logic [6:0] TRGRO_BUF_MAX = 7'h40;
  localparam logic [6:0] TRGRO_CNT_RST = 7'h00;
  typedef enum logic [1:0] {TRGRO_IDLE, TRGRO_STREAM, TRGRO_BUFFER}
    trgro_mode_t;
endpackage

/* File: rtl/trgro_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module trgro_sync
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // ==========================================================
  // Three stage sampler, change once stages two and three agree
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        sync_o <= s3_q;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/trgro_top.sv */
`timescale 1ns/1ns
`default_nettype none
module trgro_top
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] backplane_trigger_in_select_i,
  input wire logic [2:0] data_ready_out_select_i,
  input wire logic sel_we_i,
  input wire logic connector_trig_i,
  input wire logic [6:0] bp_trig_i,
  output logic [6:0] bp_trig_o,
  output logic [6:0] bp_trig_oe_o,
  output logic meas_trig_o,
  input wire logic conv_done_i,
  input wire logic [trgro_pkg::TRGRO_DATA_W-1:0] conv_data_i,
  input wire logic set_streaming_triggered_read_i,
  input wire logic set_buffered_triggered_read_i,
  input wire logic [6:0] read_count_i,
  output logic query_meter_ready_o,
  input wire logic read_stored_reading_i,
  output logic [trgro_pkg::TRGRO_DATA_W-1:0] read_data_o,
  output logic read_valid_o,
  output logic overrun_o,
  input wire logic overrun_clr_i,
  output logic data_ready_n_o
);
  import trgro_pkg::*;
  logic [2:0] in_sel_q;
  logic [2:0] out_sel_q;
  logic [6:0] bp_s;
  logic conn_s;
  logic bp_pick;
  logic [9:0] drdy_cnt_q;
  trgro_mode_t mode_q;
  logic [TRGRO_DATA_W-1:0] mem_q [TRGRO_BUF_DEPTH];
  logic [6:0] wr_q;
  logic [6:0] rd_q;
  logic [6:0] target_q;
  logic ovr_q;
  logic [6:0] level;
  logic fifo_full;
  logic take;
  logic pop;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic [6:0] target_d;
  logic [TRGRO_DATA_W-1:0] rdata_q;
  logic rvalid_q;
  logic [10:0] since_q;

  function automatic logic [6:0] line_dec(input logic [2:0] code);
    line_dec = (code == TRGRO_SEL_OFF) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
  endfunction

  // Stream ring pointers run over twice the depth
  localparam logic [6:0] RING_TOP = 7'(2 * TRGRO_FIFO_DEPTH - 1);
  localparam logic [6:0] RING_SPAN = 7'(2 * TRGRO_FIFO_DEPTH);

  function automatic logic [6:0] ptr_inc(input logic [6:0] p,
    input logic ring);
    ptr_inc = (ring && p == RING_TOP) ? 7'h00 : 7'(p + 7'h01);
  endfunction

  // ==========================================================
  // Input sampling
  trgro_sync u_conn
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(connector_trig_i),
    .sync_o(conn_s)
  );
  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : g_bp
      trgro_sync u_bp
      (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(bp_trig_i[g]),
        .sync_o(bp_s[g])
      );
    end
  endgenerate

  // ==========================================================
  // Selection registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      in_sel_q <= TRGRO_SEL_RST;
      out_sel_q <= TRGRO_SEL_RST;
    end
    else if (sel_we_i)
    begin
      in_sel_q <= backplane_trigger_in_select_i;
      out_sel_q <= data_ready_out_select_i;
    end
  end

  // ==========================================================
  // Trigger forming
  // input line decode
  assign bp_pick = |(bp_s & line_dec(in_sel_q));
  assign meas_trig_o = conn_s | bp_pick;

  // ==========================================================
  // Data ready pulse
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      drdy_cnt_q <= 10'h000;
    else if (conv_done_i)
      drdy_cnt_q <= TRGRO_DRDY_CNT;
    else if (drdy_cnt_q != 10'h000)
      drdy_cnt_q <= drdy_cnt_q - 10'h001;
  end
  assign data_ready_n_o = (drdy_cnt_q == 10'h000);
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      since_q <= 11'h7FF;
    else if (conv_done_i)
      since_q <= 11'h001;
    else if (since_q != 11'h7FF)
      since_q <= since_q + 11'h001;
  end
  assign bp_trig_oe_o = data_ready_n_o ? 7'h00 : line_dec(out_sel_q);
  assign bp_trig_o = 7'h00;

  // ==========================================================
  // Reading storage
  assign level = (mode_q == TRGRO_STREAM && wr_q < rd_q) ?
    7'(wr_q + RING_SPAN - rd_q) : 7'(wr_q - rd_q);
  assign fifo_full = (level >= 7'(TRGRO_FIFO_FULL));
  assign take = conv_done_i &&
    ((mode_q == TRGRO_STREAM && !fifo_full) ||
     (mode_q == TRGRO_BUFFER && wr_q < target_q));
  assign pop = read_stored_reading_i && (level != 7'h00) &&
    (mode_q != TRGRO_BUFFER || query_meter_ready_o);
  assign wr_idx = (mode_q == TRGRO_STREAM) ? 6'(wr_q % 7'd5) : wr_q[5:0];
  assign rd_idx = (mode_q == TRGRO_STREAM) ? 6'(rd_q % 7'd5) : rd_q[5:0];
  assign target_d = (read_count_i > TRGRO_BUF_MAX) ? TRGRO_BUF_MAX
    : read_count_i;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= TRGRO_IDLE;
      wr_q <= TRGRO_CNT_RST;
      rd_q <= TRGRO_CNT_RST;
      target_q <= TRGRO_CNT_RST;
    end
    else if (set_streaming_triggered_read_i)
    begin
      mode_q <= TRGRO_STREAM;
      wr_q <= TRGRO_CNT_RST;
      rd_q <= TRGRO_CNT_RST;
    end
    else if (set_buffered_triggered_read_i)
    begin
      mode_q <= TRGRO_BUFFER;
      wr_q <= TRGRO_CNT_RST;
      rd_q <= TRGRO_CNT_RST;
      target_q <= target_d;
    end
    else
    begin
      if (take)
        wr_q <= ptr_inc(wr_q, mode_q == TRGRO_STREAM);
      if (pop)
        rd_q <= ptr_inc(rd_q, mode_q == TRGRO_STREAM);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (take)
      mem_q[wr_idx] <= conv_data_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= pop;
      if (pop)
        rdata_q <= mem_q[rd_idx];
    end
  end
  assign read_data_o = rdata_q;
  assign read_valid_o = rvalid_q;

  assign query_meter_ready_o = (mode_q == TRGRO_BUFFER) ?
    (wr_q == target_q) : (level != 7'h00);

  // ==========================================================
  // Overrun flag
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      ovr_q <= 1'b0;
    else if (conv_done_i && mode_q == TRGRO_STREAM && fifo_full)
      ovr_q <= 1'b1;
    else if (overrun_clr_i)
      ovr_q <= 1'b0;
  end
  assign overrun_o = ovr_q;

  // ==========================================================
  // Checks
  AST_RESET_OFF: assert property (@(posedge core_clk_i)
    rst_i |=> (in_sel_q == 3'h0 && out_sel_q == 3'h0))
    else $error("select not disabled after reset");
  AST_TRIG_OR: assert property (@(posedge core_clk_i)
    disable iff (rst_i) conn_s |-> meas_trig_o)
    else $error("connector trigger lost");
  AST_SEL_OFF: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (in_sel_q == 3'h0) |-> (meas_trig_o == conn_s))
    else $error("disabled input still triggers");
  AST_DRDY_LOW: assert property (@(posedge core_clk_i)
    disable iff (rst_i) conv_done_i |=> !data_ready_n_o [*8])
    else $error("data ready pulse too short");
  AST_DRDY_SPAN: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (since_q <= 11'(TRGRO_DRDY_CYC)) |-> !data_ready_n_o)
    else $error("data ready pulse ended early");
  AST_DRDY_END: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (since_q > 11'(TRGRO_DRDY_CYC)) |-> data_ready_n_o)
    else $error("data ready pulse too long");
  AST_OUT_OFF: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (out_sel_q == 3'h0) |-> (bp_trig_oe_o == 7'h00))
    else $error("disabled output drives");
  AST_FIFO_MAX: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (mode_q == TRGRO_STREAM) |-> (level <= 7'd5))
    else $error("fifo holds more than five");
  AST_BUF_MAX: assert property (@(posedge core_clk_i)
    disable iff (rst_i) wr_q <= 7'd64)
    else $error("buffer beyond 64");
  AST_READY: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (mode_q == TRGRO_BUFFER && wr_q != target_q) |-> !query_meter_ready_o)
    else $error("ready before all readings");
  AST_OVR: assert property (@(posedge core_clk_i)
    disable iff (rst_i)
    (conv_done_i && mode_q == TRGRO_STREAM && fifo_full) |=> overrun_o)
    else $error("overrun not flagged");
endmodule
`default_nettype wire

/* File: verification/trgro_scanner.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Scanner and backplane line model
module trgro_scanner
#(
  parameter int ACT = 8
)
(
  input wire logic core_clk_i,
  input wire logic fire_i,
  input wire logic [2:0] line_i,
  input wire logic [6:0] dev_drv_i,
  input wire logic [6:0] dev_oe_i,
  output logic [6:0] lines_o
);
  logic [7:0] cnt_q = 8'h00;
  logic [2:0] sel_q = 3'h0;
  logic [6:0] scan_w;
  always_ff @(posedge core_clk_i)
  begin
    if (fire_i)
    begin
      cnt_q <= 8'(ACT);
      sel_q <= line_i;
    end
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign scan_w = (cnt_q != 8'h00) ? (7'h01 << sel_q) : 7'h00;
  assign lines_o = (scan_w & ~dev_oe_i) | (dev_drv_i & dev_oe_i);
endmodule
`default_nettype wire

/* File: verification/test_trigger_routing_readout.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t mismatch", $time); end
module test_trigger_routing_readout;
  import trgro_pkg::*;
  logic clk = 0, rst = 1, we = 0, con = 0, done = 0, str = 0, buf_m = 0;
  logic pop = 0, clr = 0, fire = 0, mt, rdy, rv, ovr, drn;
  logic [2:0] isel = 0, osel = 0, line = 0;
  logic [6:0] cnt = 0, bpi, bpo, oe;
  logic [31:0] dat = 0, rd;
  logic [31:0] q[$];
  int n_fail = 0, cmp_count = 0, seed = 32'hd912_c99e, k = 0;
  always #50 clk = ~clk;
  trgro_top dut (.core_clk_i(clk), .rst_i(rst),
    .backplane_trigger_in_select_i(isel), .data_ready_out_select_i(osel),
    .sel_we_i(we), .connector_trig_i(con), .bp_trig_i(bpi),
    .bp_trig_o(bpo), .bp_trig_oe_o(oe), .meas_trig_o(mt),
    .conv_done_i(done), .conv_data_i(dat),
    .set_streaming_triggered_read_i(str),
    .set_buffered_triggered_read_i(buf_m), .read_count_i(cnt),
    .query_meter_ready_o(rdy), .read_stored_reading_i(pop),
    .read_data_o(rd), .read_valid_o(rv), .overrun_o(ovr),
    .overrun_clr_i(clr), .data_ready_n_o(drn));
  trgro_scanner scan (.core_clk_i(clk), .fire_i(fire), .line_i(line),
    .dev_drv_i(bpo), .dev_oe_i(oe), .lines_o(bpi));
  function automatic logic [6:0] exp_oe(input int c);
    return (c == 0) ? 7'h00 : 7'(7'h01 << (c - 1));
  endfunction
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic set_sel(input int i, input int o);
    isel = 3'(i);
    osel = 3'(o);
    we = 1;
    step();
    we = 0;
  endtask
  // four settling cycles before each reading
  task automatic conv(input logic push);
    dat = $random(seed);
    if (push) q.push_back(dat);
    step(4);
    done = 1;
    step();
    done = 0;
    step();
  endtask
  task automatic take(input logic ok);
    pop = 1;
    step();
    pop = 0;
    `CHK(rv, ok)
    if (ok) begin `CHK(rd, q.pop_front()) end
    step();
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    step(10);
    rst = 0;
    step();
    `CHK(oe, 7'h00)
    `CHK(drn, 1'b1)
    line = 3'h6;
    fire = 1;
    step();
    fire = 0;
    step(5);
    `CHK(mt, 1'b0)
    step(10);
    for (int c = 0; c < 8; c++)
    begin
      set_sel(c, 0);
      for (int l = 0; l < 7; l++)
      begin
        line = 3'(l);
        fire = 1;
        step();
        fire = 0;
        step(5);
        `CHK(mt, (c != 0 && l == c - 1))
        step(8);
      end
    end
    set_sel(0, 0);
    con = 1;
    step(5);
    `CHK(mt, 1'b1)
    con = 0;
    step(5);
    for (int c = 0; c < 8; c++)
    begin
      set_sel(0, c);
      done = 1;
      step();
      done = 0;
      `CHK(drn, 1'b0)
      `CHK(oe, exp_oe(c))
      `CHK(bpo, 7'h00)
      step(999);
      `CHK(drn, 1'b0)
      step();
      `CHK(drn, 1'b1)
      `CHK(oe, 7'h00)
    end
    str = 1;
    step();
    str = 0;
    for (int i = 0; i < 6; i++) conv(i < 5);
    `CHK(ovr, 1'b1)
    `CHK(rdy, 1'b1)
    for (int i = 0; i < 5; i++) take(1);
    take(0);
    `CHK(rdy, 1'b0)
    clr = 1;
    step();
    clr = 0;
    `CHK(ovr, 1'b0)
    for (int r = 0; r < 8; r++)
    begin
      k = 1 + ($unsigned($random(seed)) % 4);
      repeat (k) conv(1);
      `CHK(rdy, 1'b1)
      repeat (k) take(1);
    end
    `CHK(ovr, 1'b0)
    cnt = 7'h40;
    buf_m = 1;
    step();
    buf_m = 0;
    for (int i = 0; i < 63; i++) conv(1);
    `CHK(rdy, 1'b0)
    take(0);
    conv(1);
    conv(0);
    `CHK(rdy, 1'b1)
    for (int i = 0; i < 64; i++) take(1);
    `CHK(q.size(), 0)
    report_and_stop();
  end
endmodule
`default_nettype wire
